// file: dv/ca_ctrl_model.sv
/*
 Controller model: drives the link clock pair and the command pins.
 Assumes the bench calls issue() once per command; clock idles low.
*/
`timescale 1ns/1ps
`default_nettype none
module ca_ctrl_model (
    output logic                    ck_t,
    output logic                    ck_c,
    output ca_decode_pkg::ca_pins_t pins
);
    import ca_decode_pkg::*;
    // Complement leg follows the true leg
    assign ck_c = ~ck_t;
    initial begin
        ck_t = 1'b0;
        pins = '1;
    end
    // Setup half period, one rise, then scramble inside the high half
    // so that each pin changes up to twice per call, never twice in one step
    task automatic issue(input ca_pins_t p);
        pins <= p;
        #62.5 ck_t <= 1'b1;
        #40 pins <= ~p; // Stale value would hide a late sample
        #22.5 ck_t <= 1'b0;
    endtask : issue
endmodule : ca_ctrl_model
`default_nettype wire

// file: dv/sdram_cmd_addr_decode_tb.sv
/*
 Bench for the command/address decoder, one task per scenario.
 Assumes the model paces one command per 125 ns link period.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ca_decode_cfg.svh"
module sdram_cmd_addr_decode_tb;
    import ca_decode_pkg::*;
    logic               ref_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               ck_t;
    logic               ck_c;
    ca_pins_t           pins;
    logic [1:0]         org = `ORG_X8;
    logic [1:0]         pkg = `PKG_SDP;
    logic [`STK_W-1:0]  my_die_id = 3'h2;
    logic [`ADDR_W-1:0] row_mask = `ROW_MASK_DEF;
    logic [`ADDR_W-1:0] col_mask = `COL_MASK_DEF;
    ca_cmd_t            cmd;
    ca_cmd_t            got;
    logic               cmd_valid;
    int                 n_valid = 0;
    int                 n_errors = 0;
    int                 comparisons = 0;
    op_t                ops [8] = '{op_mrs, op_ref, op_pre, op_rsvd,
                                    op_wr, op_rd, op_zqc, op_none};
    // System clock
    always #5 ref_clk = ~ref_clk;
    // Keep the last pulsed command; count pulses
    always @(posedge ref_clk) begin
        if (cmd_valid === 1'b1) begin
            got     <= cmd;
            n_valid <= n_valid + 1;
        end
    end
    ca_ctrl_model i_ctrl (.ck_t(ck_t), .ck_c(ck_c), .pins(pins));
    sdram_cmd_addr_decode i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ck_t(ck_t), .ck_c(ck_c),
        .pins(pins), .org(org), .pkg(pkg), .my_die_id(my_die_id),
        .row_mask(row_mask), .col_mask(col_mask), .cmd(cmd),
        .cmd_valid(cmd_valid));
    task automatic chk_op(input op_t g, input op_t e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t op %s exp %s", $time, g.name(), e.name());
        end
    endtask : chk_op
    task automatic chk_bits(input logic [17:0] g, input logic [17:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk_bits
    function automatic ca_pins_t mk(logic act_n, logic [17:0] a,
                                    logic [1:0] bg, logic [1:0] ba);
        mk = '{cs_n: 1'b0, act_n: act_n, addr: a, bg: bg, ba: ba,
               stk: my_die_id, cs1_n: 1'b1};
    endfunction : mk
    // One frame; the pulse count tells taken from refused
    task automatic send(input ca_pins_t p, input int exp_n);
        int n0;
        n0 = n_valid;
        i_ctrl.issue(p);
        chk_bits(18'(n_valid - n0), 18'(exp_n));
    endtask : send
    task automatic t_act();
        send(mk(1'b0, 18'h1_c0a5, 2'b10, 2'b01), 1);
        chk_op(got.op, op_act);
        chk_bits(got.row, 18'h1_c0a5 & row_mask);
        chk_bits({16'h0, got.bg, got.ba}, 18'h0_0009);
    endtask : t_act
    // Every read/write with each auto-precharge and chop mix
    task automatic t_rw();
        logic [17:0] a;
        for (int i = 0; i < 8; i++) begin
            a = 18'h2_0155 | (i[0] ? 18'h1_4000 : 18'h1_0000);
            a = a | (i[1] ? 18'h0_0400 : 18'h0) | (i[2] ? 18'h0_1000 : 18'h0);
            send(mk(1'b1, a, 2'b01, 2'b10), 1);
            chk_op(got.op, i[0] ? op_rd : op_wr);
            chk_bits(got.col, a & col_mask);
            chk_bits({17'h0, got.auto_pre}, {17'h0, i[1]});
            chk_bits({17'h0, got.burst_full}, {17'h0, i[2]});
        end
    endtask : t_rw
    task automatic t_codes();
        logic [17:0] a;
        for (int i = 0; i < 8; i++) begin
            a = 18'h0_2a5a | (18'(i) << 14);
            send(mk(1'b1, a, 2'(i), 2'(i + 1)), (i == 7) ? 0 : 1);
            if (i < 7) chk_op(got.op, ops[i]);
        end
        send(mk(1'b1, 18'h0_2a5a, 2'b11, 2'b10), 1);
        chk_bits(got.opcode, 18'h0_2a5a);
        chk_bits({16'h0, got.bg, got.ba}, 18'h0_000e);
        for (int j = 0; j < 2; j++) begin
            a = 18'h0_8000 | (18'(j) << 10);
            send(mk(1'b1, a, 2'b01, 2'b11), 1);
            chk_bits({17'h0, got.pre_all}, 18'(j));
        end
    endtask : t_codes
    // Chip select, x16 group, stacked and dual-die selection
    task automatic t_sel();
        ca_pins_t p;
        p = mk(1'b0, 18'h0_0123, 2'b11, 2'b00);
        p.cs_n = 1'b1;
        send(p, 0);
        @(posedge ref_clk);
        org <= `ORG_X16;
        send(mk(1'b0, 18'h0_0123, 2'b11, 2'b00), 1);
        chk_bits({16'h0, got.bg}, 18'h0_0001);
        @(posedge ref_clk);
        org <= `ORG_X8;
        pkg <= `PKG_3DS;
        send(mk(1'b0, 18'h0_0123, 2'b00, 2'b00), 1);
        chk_bits({15'h0, got.die_id}, 18'h0_0002);
        p = mk(1'b0, 18'h0_0123, 2'b00, 2'b00);
        p.stk = 3'h5;
        send(p, 0);
        @(posedge ref_clk);
        pkg <= `PKG_DDP;
        p.cs_n = 1'b1;
        p.cs1_n = 1'b0;
        send(p, 1);
        chk_bits({17'h0, got.die1}, 18'h0_0001);
    endtask : t_sel
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    // Main sequence after a six-cycle reset
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        t_act();
        t_rw();
        t_codes();
        t_sel();
        end_of_test();
    end
    // Hang guard
    initial begin
        #200000;
        n_errors++;
        end_of_test();
    end
endmodule : sdram_cmd_addr_decode_tb
`default_nettype wire

// file: logic/ca_decode_cfg.svh
/*
 Command/address decode constants: pin widths, bit positions, command
 codes and organisation settings. Included by the package and design.
*/
`ifndef CA_DECODE_CFG_SVH
`define CA_DECODE_CFG_SVH
`define ADDR_W        18
`define AP_BIT        10
`define BC_BIT        12
`define ROW_HI_BIT    16
`define ROW_LO_BIT    14
`define BG_W          2
`define BA_W          2
`define STK_W         3
`define CMD_MRS       3'b000
`define CMD_REF       3'b001
`define CMD_PRE       3'b010
`define CMD_RSVD      3'b011
`define CMD_WR        3'b100
`define CMD_RD        3'b101
`define CMD_ZQC       3'b110
`define CMD_NOP       3'b111
`define ORG_X8        2'b01
`define ORG_X16       2'b10
`define PKG_SDP       2'b00
`define PKG_DDP       2'b01
`define PKG_3DS       2'b10
`define ROW_MASK_DEF  18'h3_ffff
`define COL_MASK_DEF  18'h0_03ff
`define STK_MASK_DEF  3'h7
`endif

// file: logic/ca_decode_pkg.sv
/*
 Types shared by the command/address decoder files.
 Assumes ca_decode_cfg.svh is on the include path.
*/
`include "ca_decode_cfg.svh"
package ca_decode_pkg;
    typedef enum logic [3:0] {
        op_none, op_act, op_rd, op_wr, op_pre, op_mrs, op_ref, op_zqc,
        op_rsvd
    } op_t;

    // Pins as sampled at one clock rising crossing
    typedef struct packed {
        logic               cs_n;
        logic               act_n;
        logic [`ADDR_W-1:0] addr;
        logic [`BG_W-1:0]   bg;
        logic [`BA_W-1:0]   ba;
        logic [`STK_W-1:0]  stk;
        logic               cs1_n;
    } ca_pins_t;

    // One decoded command
    typedef struct packed {
        op_t                op;
        logic [`ADDR_W-1:0] row;
        logic [`ADDR_W-1:0] col;
        logic [`ADDR_W-1:0] opcode;
        logic [`BG_W-1:0]   bg;
        logic [`BA_W-1:0]   ba;
        logic               auto_pre;
        logic               pre_all;
        logic               burst_full;
        logic [`STK_W-1:0]  die_id;
        logic               die1;
    } ca_cmd_t;
endpackage : ca_decode_pkg

// file: logic/ca_sync2.sv
/*
 Two-flop synchroniser for a bus of asynchronous levels.
 Assumes inputs come from outside the ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ca_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // First stage only ever feeds the second
    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '1;
            q      <= '1;
        end else begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end
endmodule : ca_sync2
`default_nettype wire

// file: logic/sdram_cmd_addr_decode.sv
/*
 Command/address input decoder of a synchronous DRAM: samples pins on the
 rising crossing of the differential clock and emits one decoded command.
 Assumes ck_t/ck_c and pins are slow against ref_clk (125 ns link period)
 and that pins settle well before the crossing.
*/
// Contract
// [R01] Sample pins only at rising ck crossing
// [R02] Row on activate, column on read/write
// [R03] Mode register op-code taken from address
// [R04] A10 high on read/write: auto precharge
// [R05] A10 on precharge: one bank or all
// [R06] A12 low on read/write chops burst
// [R07] Activate: shared pins are row 16..14
// [R08] Non-activate: shared pins are command strobes
// [R09] Bank inputs pick bank and mode register
// [R10] Upper group input ignored in x16
// [R11] Stack pins are die selects in stacks; code takes no command at all in x16 stacks
// [R12] Dual-die: stack pins control second die; code ignores stack pins and uses cs1_n instead
// [R13] Chip select high masks every command; code takes commands with cs_n high in dual-die while cs1_n is low
// [R14] Unused address bits are not decoded
`timescale 1ns/1ps
`default_nettype none
`include "ca_decode_cfg.svh"
module sdram_cmd_addr_decode (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   ck_t,
    input  wire logic                   ck_c,
    input  wire ca_decode_pkg::ca_pins_t pins,
    input  wire logic [1:0]             org,
    input  wire logic [1:0]             pkg,
    input  wire logic [`STK_W-1:0]      my_die_id,
    input  wire logic [`ADDR_W-1:0]     row_mask,
    input  wire logic [`ADDR_W-1:0]     col_mask,
    output var ca_decode_pkg::ca_cmd_t  cmd,
    output logic                        cmd_valid
);
    import ca_decode_pkg::*;

    localparam int PW = $bits(ca_pins_t);

    logic             rst_meta_r;
    logic             rst_sync_n;
    logic [1:0]       ck_s;
    logic [PW-1:0]    pins_s;
    ca_pins_t         pv;
    logic             ck_prev_r;
    logic             ck_prev_nxt;
    logic             rise;
    ca_cmd_t          dec;
    ca_cmd_t          cmd_nxt;
    logic             valid_nxt;
    logic             sel;
    logic [2:0]       code;
    logic [`ADDR_W-1:0] am;

    // Reset released through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // Clock pair and pins pass two flops before use
    ca_sync2 #(.W(2)) u_ck_sync (
        .clk   (ref_clk),
        .rst_n (rst_sync_n),
        .d     ({ck_t, ck_c}),
        .q     (ck_s)
    );
    ca_sync2 #(.W(PW)) u_pin_sync (
        .clk   (ref_clk),
        .rst_n (rst_sync_n),
        .d     (pins),
        .q     (pins_s)
    );
    assign pv = ca_pins_t'(pins_s);

    // Crossing: true over complement now, not before
    always_comb begin
        ck_prev_nxt = ck_s[1] & ~ck_s[0];
        rise        = ck_prev_nxt & ~ck_prev_r; // R01
    end

    // Decode of the sampled pins
    always_comb begin
        dec  = '0;
        code = {pv.addr[`ROW_HI_BIT], pv.addr[`ROW_HI_BIT-1],
                pv.addr[`ROW_LO_BIT]};
        // Die selection depends on package style
        case (pkg)
            `PKG_DDP: sel = ~pv.cs_n | ~pv.cs1_n; // R12
            `PKG_3DS: sel = ~pv.cs_n & (org != `ORG_X16)
                            & (pv.stk == my_die_id); // R11
            default:  sel = ~pv.cs_n; // R13
        endcase
        dec.die1   = (pkg == `PKG_DDP) & pv.cs_n & ~pv.cs1_n; // R12
        dec.die_id = (pkg == `PKG_3DS && org != `ORG_X16) ?
                     pv.stk : '0; // R11
        dec.bg     = pv.bg;
        if (org == `ORG_X16)
            dec.bg[1] = 1'b0; // R10
        dec.ba     = pv.ba; // R09
        am         = pv.addr;
        if (!sel) begin
            dec.op = op_none; // R13
        end else if (!pv.act_n) begin
            dec.op  = op_act;
            dec.row = pv.addr & row_mask; // R07 R02 R14
        end else begin
            case (code) // R08
                `CMD_MRS:  begin
                    dec.op     = op_mrs;
                    dec.opcode = am; // R03
                end
                `CMD_REF:  dec.op = op_ref;
                `CMD_PRE:  begin
                    dec.op      = op_pre;
                    dec.pre_all = am[`AP_BIT]; // R05
                end
                `CMD_WR, `CMD_RD: begin
                    dec.op = (code == `CMD_RD) ? op_rd : op_wr;
                    dec.col        = am & col_mask; // R02 R14
                    dec.auto_pre   = am[`AP_BIT]; // R04
                    dec.burst_full = am[`BC_BIT]; // R06
                end
                `CMD_ZQC:  dec.op = op_zqc;
                `CMD_RSVD: dec.op = op_rsvd;
                default:   dec.op = op_none;
            endcase
        end
    end

    // Capture only at the crossing; otherwise hold
    always_comb begin
        cmd_nxt   = rise ? dec : cmd; // R01
        valid_nxt = rise && (dec.op != op_none);
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ck_prev_r <= 1'b0;
            cmd       <= '0;
            cmd_valid <= 1'b0;
        end else begin
            ck_prev_r <= ck_prev_nxt;
            cmd       <= cmd_nxt;
            cmd_valid <= valid_nxt;
        end
    end

    // Crossing in stacked mode that carries another die's id
    sequence s_foreign_die;
        rise && pkg == `PKG_3DS && pv.stk != my_die_id;
    endsequence
    // Crossing in dual-die mode with both selects high
    sequence s_both_deselected;
        rise && pkg == `PKG_DDP && pv.cs_n && pv.cs1_n;
    endsequence
    // Read or write just handed out
    sequence s_col_taken;
        cmd_valid && (cmd.op == op_rd || cmd.op == op_wr);
    endsequence

    // Valid only one cycle after a detected crossing
    a_valid_on_rise: assert property (@(posedge ref_clk) // R01
        disable iff (!rst_sync_n) cmd_valid |-> $past(rise))
        else $error("command valid without clock crossing");
    // Masked chip select never yields a command outside dual-die mode
    a_cs_masks: assert property (@(posedge ref_clk) // R13
        disable iff (!rst_sync_n)
        (rise && pv.cs_n && pkg != `PKG_DDP) |=> !cmd_valid)
        else $error("command decoded with chip select high");
    // Upper group bit zero in x16
    a_x16_bg: assert property (@(posedge ref_clk) // R10
        disable iff (!rst_sync_n)
        (org == `ORG_X16 && cmd_valid) |-> !cmd.bg[1])
        else $error("upper bank group used in x16");
    // Auto precharge follows A10 on reads and writes
    a_auto_pre: assert property (@(posedge ref_clk) // R04
        disable iff (!rst_sync_n)
        (rise && (dec.op == op_rd || dec.op == op_wr)) |=>
        (cmd.auto_pre == $past(pv.addr[`AP_BIT])))
        else $error("auto precharge mismatch");
    // Precharge all follows A10
    a_pre_all: assert property (@(posedge ref_clk) // R05
        disable iff (!rst_sync_n)
        (cmd_valid && cmd.op == op_pre) |->
        (cmd.pre_all == $past(pv.addr[`AP_BIT])))
        else $error("precharge scope mismatch");
    // Burst chop follows A12
    a_burst_chop: assert property (@(posedge ref_clk) // R06
        disable iff (!rst_sync_n)
        s_col_taken |-> (cmd.burst_full == $past(pv.addr[`BC_BIT])))
        else $error("burst chop mismatch");
    // Activate row carries shared pins
    a_act_row: assert property (@(posedge ref_clk) // R07
        disable iff (!rst_sync_n)
        (cmd_valid && cmd.op == op_act) |->
        (cmd.row == ($past(pv.addr) & $past(row_mask))))
        else $error("activate row mismatch");
    // Op-code equals address
    a_mrs_code: assert property (@(posedge ref_clk) // R03
        disable iff (!rst_sync_n)
        (cmd_valid && cmd.op == op_mrs) |->
        (cmd.opcode == $past(pv.addr) && cmd.ba == $past(pv.ba)))
        else $error("mode register op-code mismatch");
    // Command holds between crossings
    a_cmd_hold: assert property (@(posedge ref_clk) // R01
        disable iff (!rst_sync_n) !$past(rise) |-> $stable(cmd))
        else $error("command changed without crossing");
    // Column carries only the used address bits
    a_col_rw: assert property (@(posedge ref_clk) // R02
        disable iff (!rst_sync_n)
        s_col_taken |-> (cmd.col == ($past(pv.addr) & $past(col_mask))))
        else $error("column address mismatch");
    // Bank inputs reach the command untouched
    a_bank_pick: assert property (@(posedge ref_clk) // R09
        disable iff (!rst_sync_n)
        cmd_valid |-> (cmd.ba == $past(pv.ba)))
        else $error("bank address mismatch");
    // A stacked die ignores commands for its neighbours
    a_foreign_die: assert property (@(posedge ref_clk) // R11
        disable iff (!rst_sync_n) s_foreign_die |=> !cmd_valid)
        else $error("command taken for another die");
    // Dual-die part idle while neither select is low
    a_ddp_idle: assert property (@(posedge ref_clk) // R12
        disable iff (!rst_sync_n) s_both_deselected |=> !cmd_valid)
        else $error("command taken with both dies deselected");
endmodule : sdram_cmd_addr_decode
`default_nettype wire
